// ===== src/encpf_frame.sv
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
// Function
// - First falling clock edge starts cycle, latches values
// - Start bit after position calculation time
// - Error bit one, error two for extended
// - Error two independent, sent inverted
// - Error flag set on fault, cause stored
// - Position word sent least significant bit first
// - Check field follows last position bit
// - Extended: datum one, datum two, each checked
// - Data low after recovery interval, two ranges
// - Datum 30 bits, first bit low
// - Datum check excludes first bit and check
// - Sixteen numbered contents per slot, number echoed
// - Selection applies from next commands 8 to 13
// - Selection stays until deselect or new selection
// - No datum selected after power-up
// - Selection command pattern is 001001
// - Codes 4C, 4D temperatures, 59 error source
// - Warning bit on tolerance limit, cause stored
// - Reference bit: run done, high if absolute
// - Mode bits redundant, corrupted command reported
// - Busy high while a request is processed
// - Datum number five bits, sent inside datum
module encpf_frame
   import encpf_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              arst_n,
   input  wire logic              linkClk,
   input  wire logic              dataIn,
   output logic                   dataOut,
   output logic                   dataOe,
   input  wire logic [POS_W-1:0]  posValue,
   input  wire logic              fault1,
   input  wire logic              fault2,
   input  wire logic [3:0]        warnCause,
   input  wire logic              refDoneIn,
   input  wire logic [15:0]       tempA,
   input  wire logic [15:0]       tempB,
   input  wire logic [7:0]        regAddr,
   input  wire logic [31:0]       regWrData,
   input  wire logic              regWrEn,
   input  wire logic              regRdEn,
   output logic [31:0]            regRdData
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic [4:0] crc5(input logic [63:0] d, input logic [6:0] n);
      logic [4:0] c;
      logic       fb;
      c = CRC_INIT;
      for (int i = 0; i < 64; i++) begin
         if (7'(i) < n) begin
            fb = d[i] ^ c[4];
            c  = {c[3:0], 1'b0} ^ (fb ? CRC_POLY : 5'h00);
         end
      end
      return c;
   endfunction

   function automatic logic [3:0] modeDecode(input logic [5:0] m);
      logic [3:0] n;
      n = CMD_NONE;
      case (m)
         MODE_POS:    n = 4'h1;
         MODE_AREA:   n = 4'h2;
         MODE_RXPAR:  n = 4'h3;
         MODE_TXPAR:  n = 4'h4;
         MODE_RESET:  n = 4'h5;
         MODE_TXTEST: n = 4'h6;
         MODE_RXTEST: n = 4'h7;
         MODE_POSADD: n = 4'h8;
         MODE_POSSEL: n = 4'h9;
         MODE_POSRXP: n = 4'hA;
         MODE_POSTXP: n = 4'hB;
         MODE_POSERR: n = 4'hC;
         MODE_POSTST: n = 4'hD;
         MODE_COMM:   n = 4'hE;
         default:     n = CMD_NONE;
      endcase
      return n;
   endfunction

   function automatic logic isExt(input logic [3:0] c);
      return (c >= CMD_EXT_FIRST) && (c <= CMD_EXT_LAST);
   endfunction

   // Datum word plus its check field, first bit low
   function automatic logic [DAT_W+CRC_W-1:0] mkDatum(
      input logic [7:0]       code,
      input logic             tol,
      input logic             home,
      input logic             busy,
      input logic [VAL_W-1:0] val
   );
      logic [DAT_W-1:0] d;
      d = {val, code[4:0], busy, home, tol, 1'b0};
      return {crc5(64'(d[DAT_W-1:1]), CRC_LEN_DAT), d};
   endfunction

   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic rstMeta_q;
   logic rstN_q;
   logic clkMeta_q;
   logic clkSync_q;
   logic clkPrev_q;
   logic datMeta_q;
   logic datSync_q;
   logic linkFall;
   logic linkRise;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta_q <= 1'b0;
         rstN_q    <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN_q    <= rstMeta_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         clkMeta_q <= 1'b1;
         clkSync_q <= 1'b1;
         clkPrev_q <= 1'b1;
         datMeta_q <= 1'b0;
         datSync_q <= 1'b0;
      end else begin
         clkMeta_q <= linkClk;
         clkSync_q <= clkMeta_q;
         clkPrev_q <= clkSync_q;
         datMeta_q <= dataIn;
         datSync_q <= datMeta_q;
      end
   end

   assign linkFall = clkPrev_q & ~clkSync_q;
   assign linkRise = ~clkPrev_q & clkSync_q;

   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   encpf_state_t         state_q;
   logic [6:0]           bitCnt_q;
   logic [11:0]          timer_q;
   logic [11:0]          highCnt_q;
   logic [5:0]           modeSh_q;
   logic [7:0]           rngSh_q;
   logic [3:0]           cmd_q;
   logic [5:0]           lastMode_q;
   logic                 calcDone_q;
   logic [FRAME_W-1:0]   txShift_q;
   logic [6:0]           txLeft_q;
   logic                 dataOut_q;
   logic [POS_W-1:0]     pos_q;
   logic                 fault1_q;
   logic                 fault2_q;
   logic [3:0]           warn_q;
   logic                 ref_q;
   logic                 modeErr_q;
   logic [1:0]           ctrl_q;
   logic [7:0]           cause_q;
   logic [7:0]           selPend_q;
   logic                 pendValid_q;
   logic [7:0]           sel1_q;
   logic [7:0]           sel2_q;
   logic                 act1_q;
   logic                 act2_q;
   logic [7:0]           lastRng_q;
   logic [15:0]          frames_q;
   logic [31:0]          rdData_q;

   logic                 startPulse;
   logic                 modeDone;
   logic [5:0]           modeWord;
   logic [3:0]           cmdNext;
   logic                 rngDone;
   logic                 abortFrame;
   logic [11:0]          recovCyc;

   assign startPulse = (state_q == ST_IDLE) && linkFall;
   assign modeWord   = {modeSh_q[4:0], datSync_q};
   assign modeDone   = (state_q == ST_MODE) && linkFall && (bitCnt_q == MODE_LAST);
   assign cmdNext    = modeDecode(modeWord);
   assign rngDone    = (state_q == ST_RNG) && linkFall && (bitCnt_q == RNG_LAST);
   assign abortFrame = (state_q != ST_IDLE) && (state_q != ST_RECOV)
                       && (highCnt_q == ABORT_CYC);
   assign recovCyc   = (ctrl_q[CTRL_SHORT] && isExt(cmd_q)) ? RECOV_SHORT_CYC
                                                            : RECOV_LONG_CYC;

   // ----------------------------------------------------------------
   // Frame contents
   // ----------------------------------------------------------------
   logic                       err1;
   logic                       err2;
   logic                       tolBit;
   logic                       refBit;
   logic [DAT_W+CRC_W-1:0]     dat1;
   logic [DAT_W+CRC_W-1:0]     dat2;
   logic [FRAME_W-1:0]         frame;
   logic [6:0]                 frameLen;

   function automatic logic [VAL_W-1:0] datumValue(input logic [7:0] code,
                                                   input logic [15:0] ta,
                                                   input logic [15:0] tb,
                                                   input logic [7:0] cause);
      logic [VAL_W-1:0] v;
      v = VAL_W'(code);
      if (code == RNG_TEMPA) begin
         v = VAL_W'(ta);
      end else if (code == RNG_TEMPB) begin
         v = VAL_W'(tb);
      end else if (code == RNG_ERR_SRC) begin
         v = VAL_W'(cause);
      end
      return v;
   endfunction

   assign err1   = fault1_q | modeErr_q;
   assign err2   = ~fault2_q;
   assign tolBit = |warn_q;
   assign refBit = ctrl_q[CTRL_ABS] | ref_q;
   assign dat1   = mkDatum(sel1_q, tolBit, refBit, pendValid_q,
                           datumValue(sel1_q, tempA, tempB, cause_q));
   assign dat2   = mkDatum(sel2_q, tolBit, refBit, pendValid_q,
                           datumValue(sel2_q, tempA, tempB, cause_q));

   always_comb begin
      frame    = '0;
      frameLen = LEN_BASIC;
      if (isExt(cmd_q)) begin
         frame = {(act1_q ? dat2 : '0),
                  (act1_q ? dat1 : dat2),
                  crc5(64'({pos_q, err2, err1}), CRC_LEN_POS2),
                  pos_q, err2, err1, 1'b1};
         if (act1_q && act2_q) begin
            frameLen = 7'(LEN_EXT + LEN_DATUM + LEN_DATUM);
         end else if (act1_q || act2_q) begin
            frameLen = 7'(LEN_EXT + LEN_DATUM);
         end else begin
            frameLen = LEN_EXT;
         end
      end else begin
         frame = FRAME_W'({crc5(64'({pos_q, err1}), CRC_LEN_POS1),
                           pos_q, err1, 1'b1});
      end
   end

   // ----------------------------------------------------------------
   // Link sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         state_q    <= ST_IDLE;
         bitCnt_q   <= '0;
         timer_q    <= '0;
         modeSh_q   <= '0;
         rngSh_q    <= '0;
         cmd_q      <= CMD_NONE;
         calcDone_q <= 1'b0;
         txShift_q  <= '0;
         txLeft_q   <= '0;
         dataOut_q  <= 1'b0;
      end else if (abortFrame) begin
         state_q <= ST_RECOV;
         timer_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               dataOut_q <= 1'b0;
               if (linkFall) begin
                  state_q  <= ST_MODE;
                  bitCnt_q <= '0;
               end
            end
            ST_MODE: begin
               if (linkFall) begin
                  bitCnt_q <= bitCnt_q + 7'h01;
                  if (bitCnt_q >= MODE_FIRST) begin
                     modeSh_q <= modeWord;
                  end
                  if (modeDone) begin
                     cmd_q    <= cmdNext;
                     bitCnt_q <= '0;
                     timer_q  <= '0;
                     if (cmdNext == CMD_SEL) begin
                        state_q <= ST_RNG;
                     end else begin
                        state_q    <= ST_CALC;
                        calcDone_q <= 1'b0;
                     end
                  end
               end
            end
            ST_RNG: begin
               if (linkFall) begin
                  bitCnt_q <= bitCnt_q + 7'h01;
                  rngSh_q  <= {rngSh_q[6:0], datSync_q};
                  if (rngDone) begin
                     state_q    <= ST_CALC;
                     timer_q    <= '0;
                     calcDone_q <= 1'b0;
                  end
               end
            end
            ST_CALC: begin
               if (timer_q == TCAL_CYC) begin
                  calcDone_q <= 1'b1;
               end else begin
                  timer_q <= timer_q + 12'h001;
               end
               if (calcDone_q && linkRise) begin
                  state_q   <= ST_SEND;
                  dataOut_q <= frame[0];
                  txShift_q <= frame >> 1;
                  txLeft_q  <= frameLen - 7'h01;
               end
            end
            ST_SEND: begin
               if (linkRise) begin
                  if (txLeft_q == 7'h00) begin
                     state_q   <= ST_RECOV;
                     dataOut_q <= 1'b1;
                     timer_q   <= '0;
                  end else begin
                     dataOut_q <= txShift_q[0];
                     txShift_q <= txShift_q >> 1;
                     txLeft_q  <= txLeft_q - 7'h01;
                  end
               end
            end
            ST_RECOV: begin
               dataOut_q <= 1'b1;
               if (!clkSync_q) begin
                  timer_q <= '0;
               end else if (timer_q >= recovCyc) begin
                  state_q   <= ST_IDLE;
                  dataOut_q <= 1'b0;
               end else begin
                  timer_q <= timer_q + 12'h001;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Clock-high watchdog for a master that stops mid-frame
   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         highCnt_q <= '0;
      end else if (!clkSync_q || state_q == ST_IDLE) begin
         highCnt_q <= '0;
      end else if (highCnt_q != ABORT_CYC) begin
         highCnt_q <= highCnt_q + 12'h001;
      end
   end

   // ----------------------------------------------------------------
   // Measured value latch
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         pos_q    <= '0;
         fault1_q <= 1'b0;
         fault2_q <= 1'b0;
         warn_q   <= '0;
         ref_q    <= 1'b0;
      end else if (startPulse) begin
         pos_q    <= posValue;
         fault1_q <= fault1;
         fault2_q <= fault2;
         warn_q   <= warnCause;
         ref_q    <= refDoneIn;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         modeErr_q  <= 1'b0;
         lastMode_q <= '0;
      end else if (modeDone) begin
         modeErr_q  <= (cmdNext == CMD_NONE);
         lastMode_q <= modeWord;
      end
   end

   // ----------------------------------------------------------------
   // Additional data selection
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         selPend_q   <= '0;
         pendValid_q <= 1'b0;
         lastRng_q   <= '0;
      end else if (rngDone) begin
         selPend_q   <= {rngSh_q[6:0], datSync_q};
         lastRng_q   <= {rngSh_q[6:0], datSync_q};
         pendValid_q <= 1'b1;
      end else if (modeDone && isExt(cmdNext)) begin
         pendValid_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         act1_q <= 1'b0;
         act2_q <= 1'b0;
         sel1_q <= '0;
         sel2_q <= '0;
      end else if (modeDone && isExt(cmdNext) && pendValid_q) begin
         if (selPend_q == RNG_DESELECT) begin
            act1_q <= 1'b0;
            act2_q <= 1'b0;
         end else if (selPend_q[7:4] == RNG_SLOT1) begin
            act1_q <= 1'b1;
            sel1_q <= selPend_q;
         end else if (selPend_q[7:4] == RNG_SLOT2) begin
            act2_q <= 1'b1;
            sel2_q <= selPend_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   logic [7:0] causeSet;

   assign causeSet = startPulse ? {warnCause, 1'b0, 1'b0, fault2, fault1}
                                : {4'h0, 1'b0, modeDone && (cmdNext == CMD_NONE),
                                   2'b00};

   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         ctrl_q <= CTRL_RESET;
      end else if (regWrEn && regAddr == REG_CTRL) begin
         ctrl_q <= regWrData[1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         cause_q <= '0;
      end else if (regWrEn && regAddr == REG_CAUSE) begin
         cause_q <= (cause_q & ~regWrData[7:0]) | causeSet;
      end else begin
         cause_q <= cause_q | causeSet;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         frames_q <= '0;
      end else if (startPulse) begin
         frames_q <= frames_q + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         rdData_q <= '0;
      end else if (!regRdEn) begin
         rdData_q <= '0;
      end else if (regAddr == REG_CTRL) begin
         rdData_q <= {30'h0, ctrl_q};
      end else if (regAddr == REG_STATUS) begin
         rdData_q <= {4'h0, cmd_q, 2'b00, lastMode_q, lastRng_q,
                      1'b0, state_q, act2_q, act1_q, 1'b0, pendValid_q};
      end else if (regAddr == REG_CAUSE) begin
         rdData_q <= {24'h0, cause_q};
      end else if (regAddr == REG_SEL) begin
         rdData_q <= {16'h0, sel2_q, sel1_q};
      end else if (regAddr == REG_FRAMES) begin
         rdData_q <= {16'h0, frames_q};
      end else begin
         rdData_q <= '0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign dataOut   = dataOut_q;
   assign dataOe    = (state_q != ST_MODE) && (state_q != ST_RNG);
   assign regRdData = rdData_q;

endmodule

// ===== src/encpf_pkg.sv
package encpf_pkg;

   // ----------------------------------------------------------------
   // Frame geometry
   // ----------------------------------------------------------------
   localparam int          POS_W         = 25;
   localparam int          CRC_W         = 5;
   localparam int          DAT_W         = 30;
   localparam int          VAL_W         = 21;
   localparam int          FRAME_W       = 103;
   localparam logic [6:0]  LEN_BASIC     = 7'h20;
   localparam logic [6:0]  LEN_EXT       = 7'h21;
   localparam logic [6:0]  LEN_DATUM     = 7'h23;
   localparam logic [6:0]  CRC_LEN_POS1  = 7'h1A;
   localparam logic [6:0]  CRC_LEN_POS2  = 7'h1B;
   localparam logic [6:0]  CRC_LEN_DAT   = 7'h1D;
   localparam logic [4:0]  CRC_POLY      = 5'h0B;
   localparam logic [4:0]  CRC_INIT      = 5'h1F;

   // ----------------------------------------------------------------
   // Receive positions, counted in falling edges after the first
   // ----------------------------------------------------------------
   localparam logic [6:0]  MODE_FIRST    = 7'h01;
   localparam logic [6:0]  MODE_LAST     = 7'h06;
   localparam logic [6:0]  RNG_LAST      = 7'h07;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          TCAL_NS       = 5000;
   localparam int          RECOV_LONG_NS = 10000;
   localparam int          RECOV_SHORT_NS = 1250;
   localparam int          ABORT_NS      = 30000;
   localparam logic [11:0] TCAL_CYC      = 12'(TCAL_NS / CLK_PERIOD_NS);
   localparam logic [11:0] RECOV_LONG_CYC =
      12'((RECOV_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] RECOV_SHORT_CYC =
      12'((RECOV_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] ABORT_CYC     = 12'(ABORT_NS / CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // Mode commands: three bits then their redundant copy, inverted in MODE_POS to MODE_POSADD
   // ----------------------------------------------------------------
   localparam logic [5:0]  MODE_POS      = 6'h07;
   localparam logic [5:0]  MODE_AREA     = 6'h0E;
   localparam logic [5:0]  MODE_RXPAR    = 6'h1C;
   localparam logic [5:0]  MODE_TXPAR    = 6'h23;
   localparam logic [5:0]  MODE_RESET    = 6'h2A;
   localparam logic [5:0]  MODE_TXTEST   = 6'h15;
   localparam logic [5:0]  MODE_RXTEST   = 6'h31;
   localparam logic [5:0]  MODE_POSADD   = 6'h38;
   localparam logic [5:0]  MODE_POSSEL   = 6'h09;
   localparam logic [5:0]  MODE_POSRXP   = 6'h1B;
   localparam logic [5:0]  MODE_POSTXP   = 6'h24;
   localparam logic [5:0]  MODE_POSERR   = 6'h2D;
   localparam logic [5:0]  MODE_POSTST   = 6'h36;
   localparam logic [5:0]  MODE_COMM     = 6'h12;
   localparam logic [3:0]  CMD_NONE      = 4'h0;
   localparam logic [3:0]  CMD_EXT_FIRST = 4'h8;
   localparam logic [3:0]  CMD_SEL       = 4'h9;
   localparam logic [3:0]  CMD_EXT_LAST  = 4'hD;

   // ----------------------------------------------------------------
   // Memory range select codes
   // ----------------------------------------------------------------
   localparam logic [3:0]  RNG_SLOT1     = 4'h4;
   localparam logic [3:0]  RNG_SLOT2     = 4'h5;
   localparam logic [7:0]  RNG_DESELECT  = 8'h60;
   localparam logic [7:0]  RNG_TEMPA     = 8'h4C;
   localparam logic [7:0]  RNG_TEMPB     = 8'h4D;
   localparam logic [7:0]  RNG_ERR_SRC   = 8'h59;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL      = 8'h00;
   localparam logic [7:0]  REG_STATUS    = 8'h04;
   localparam logic [7:0]  REG_CAUSE     = 8'h08;
   localparam logic [7:0]  REG_SEL       = 8'h0C;
   localparam logic [7:0]  REG_FRAMES    = 8'h10;
   localparam logic [1:0]  CTRL_RESET    = 2'h0;
   localparam int          CTRL_SHORT    = 0;
   localparam int          CTRL_ABS      = 1;
   localparam int          CAUSE_FAULT1  = 0;
   localparam int          CAUSE_FAULT2  = 1;
   localparam int          CAUSE_MODE    = 2;
   localparam int          CAUSE_WARN    = 4;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_MODE  = 3'b001,
      ST_RNG   = 3'b010,
      ST_CALC  = 3'b011,
      ST_SEND  = 3'b100,
      ST_RECOV = 3'b101
   } encpf_state_t;

endpackage

// ===== tb/encpf_frame_chk.sv
`timescale 1ns/100ps
module encpf_frame_chk
   import encpf_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic        linkClk,
   input wire logic        dataOut,
   input wire logic        dataOe,
   input wire logic [7:0]  regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWrEn,
   input wire logic        regRdEn,
   input wire logic [31:0] regRdData
);
   // ----
   // Link clock high time and recovery mode
   // ----
   logic [11:0] hiCnt_q;
   logic        short_q;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) hiCnt_q <= 12'h000;
      else if (!linkClk) hiCnt_q <= 12'h000;
      else if (hiCnt_q != 12'hFFF) hiCnt_q <= hiCnt_q + 12'h001;
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) short_q <= 1'b0;
      else if (regWrEn && regAddr == REG_CTRL) short_q <= regWrData[CTRL_SHORT];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_quiet;
      !dataOut [*8];
   endsequence
   AST_RD_IDLE: assert property (!$past(regRdEn) |-> regRdData == 32'h0)
      else $error("read data outside read slot");
   AST_RD_UNMAP: assert property ($past(regRdEn) && $past(regAddr) == 8'h14 |-> !regRdData)
      else $error("unmapped read not zero");
   AST_RECOV_MIN: assert property ($fell(dataOut) && hiCnt_q > 12'h014 |->
      hiCnt_q >= (short_q ? 12'h07C : 12'h3E8)) else $error("recovery too short");
   AST_RECOV_MAX: assert property (dataOut |-> hiCnt_q < 12'h3F2)
      else $error("recovery too long");
   AST_RX_CLOCKED: assert property (!dataOe |-> hiCnt_q < 12'h014)
      else $error("data pin released while link idle");
   AST_RESET_IDLE: assert property ($rose(arst_n) |-> (dataOe && !dataOut) [*2])
      else $error("data pin not low after reset");
   AST_CALC_LOW: assert property ($rose(dataOe) |-> s_quiet)
      else $error("start bit before calculation");
   AST_STABLE_LOW: assert property ((dataOe && !linkClk) [*5] |-> $stable(dataOut))
      else $error("data changed in clock low phase");
endmodule
bind encpf_frame encpf_frame_chk u_chk (.sys_clk, .arst_n, .linkClk, .dataOut, .dataOe,
   .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData);

// ===== tb/encpf_link_master.sv
`timescale 1ns/100ps
module encpf_link_master (
   output logic      linkClk,
   output logic      dataIn,
   input  wire logic dataOut,
   input  wire logic dataOe
);
   logic drvOn;
   logic txBit;
   assign dataIn = dataOe ? dataOut : (drvOn ? txBit : ~dataOut);
   initial begin
      linkClk = 1'b1;
      drvOn = 1'b0;
      txBit = 1'b0;
   end
   task automatic frame(input logic [13:0] cmd, output logic [255:0] rx);
      rx = '0;
      #1;
      drvOn = 1'b1;
      for (int i = 1; i <= 240; i++) begin
         #62.5;
         linkClk = 1'b0;
         if (i > 16) rx = {dataIn, rx[255:1]};
         #62.5;
         linkClk = 1'b1;
         if (i > 1 && i < 16) txBit = cmd[15-i];
         drvOn = (i < 16);
      end
   endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb
   import encpf_pkg::*;
;
   logic             sys_clk, arst_n, linkClk, dataIn, dataOut, dataOe;
   logic             fault1, fault2, refDoneIn, regWrEn, regRdEn;
   logic [POS_W-1:0] posValue;
   logic [3:0]       warnCause;
   logic [15:0]      tempA, tempB;
   logic [7:0]       regAddr;
   logic [31:0]      regWrData, regRdData, rdv;
   logic [255:0]     b;
   int               mismatches, compares, n;
   encpf_frame u_dut (.sys_clk, .arst_n, .linkClk, .dataIn, .dataOut, .dataOe, .posValue,
      .fault1, .fault2, .warnCause, .refDoneIn, .tempA, .tempB, .regAddr, .regWrData,
      .regWrEn, .regRdEn, .regRdData);
   encpf_link_master u_mst (.linkClk, .dataIn, .dataOut, .dataOe);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // ----
   // Shared tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("Compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {regAddr, regWrData, regWrEn} <= {a, d, 1'b1};
      @(posedge sys_clk);
      regWrEn <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      {regAddr, regRdEn} <= {a, 1'b1};
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      @(negedge sys_clk);
      rdv = regRdData;
   endtask
   function automatic logic [4:0] crc5(input logic [255:0] v, input int hi);
      logic [4:0] c;
      c = CRC_INIT;
      for (int i = 1; i <= hi; i++) c = {c[3:0], 1'b0} ^ ((c[4] ^ v[i]) ? CRC_POLY : 5'h00);
      return c;
   endfunction
   task automatic run(input logic [13:0] cmd);
      u_mst.frame(cmd, b);
      for (n = 0; n < 256 && b[0] !== 1'b1; n++) b = b >> 1;
      for (n = 0; n < 2000 && dataOut !== 1'b0; n++) @(negedge sys_clk);
      chk(n < 2000, 1);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_basic();
      {posValue, fault1} <= {25'h1A5C3E7, 1'b1};
      run({MODE_POS, 8'h00});
      chk(b[1:0], 2'b11);
      chk(b[26:2], 25'h1A5C3E7);
      chk(b[31:27], crc5(b, 26));
      chk(n >= 1000 && n <= 1010, 1);
      rd(REG_CAUSE);
      chk(rdv[CAUSE_FAULT1], 1);
      rd(8'h14);
      chk(rdv, 0);
   endtask
   task automatic t_ext();
      wr(REG_CTRL, 32'h3);
      {fault1, warnCause, tempA, tempB} <= {1'b0, 4'h2, 16'hBEEF, 16'h1234};
      run({MODE_POSADD, 8'h00});
      chk({b[33], b[2:1]}, 3'b110);
      chk(n >= 125 && n <= 135, 1);
      run({MODE_POSSEL, RNG_TEMPA});
      chk(b[33], 1);
      rd(REG_STATUS);
      chk(rdv[0], 1);
      run({MODE_POSSEL, RNG_ERR_SRC});
      run({MODE_POSADD, 8'h00});
      chk(b[41:33], 9'h0C6);
      chk(b[62:42], 21'h0BEEF);
      chk(b[67:63], crc5(b >> 33, 29));
      chk({b[76:72], b[68]}, 6'h32);
      run({MODE_POSSEL, RNG_TEMPB});
      run({MODE_POSSEL, RNG_DESELECT});
      chk({b[62:42], b[41:37]}, 26'h2468D);
      run({MODE_POSADD, 8'h00});
      chk(b[33], 1);
   endtask
   task automatic t_mode();
      run(14'h0000);
      chk(b[1], 1);
      rd(REG_CAUSE);
      chk(rdv[CAUSE_MODE], 1);
   endtask
   initial begin
      {arst_n, regWrEn, regRdEn, fault1, fault2, refDoneIn} = '0;
      {posValue, warnCause, tempA, tempB, regAddr, regWrData} = '0;
      {mismatches, compares} = '0;
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_basic();
      t_ext();
      t_mode();
      results();
   end
   initial begin
      #1000000;
      mismatches++;
      results();
   end
endmodule
